// ==== verilog/dcrb_pkg.sv ====
// constants shared by the two-channel synthesizer channel register bank
// assumes the serial control port logic hands over whole register words
package dcrb_pkg;
  // ---------------------------------------------------------------
  // register addresses on the serial control port
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_CHANNEL_SELECTION = 5'h00;
  localparam logic [4:0] ADDR_CHANNEL_FUNCTION = 5'h03;
  localparam logic [4:0] ADDR_PHASE_OFFSET_WORD = 5'h05;
  localparam logic [4:0] ADDR_AMPLITUDE_CONTROL = 5'h06;
  localparam logic [4:0] ADDR_SWEEP_RAMP_RATE = 5'h07;
  localparam logic [4:0] ADDR_RISING_DELTA_WORD = 5'h08;
  localparam logic [4:0] ADDR_FALLING_DELTA_WORD = 5'h09;

  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int CHAN_ENABLE_LSB = 6;
  localparam int CHAN_ENABLE_MSB = 7;
  localparam int CLEAR_PHASE_BIT = 1;
  localparam int PHASE_OFFSET_BITS = 14;
  localparam int AMPLITUDE_BITS = 24;
  localparam int RAMP_RATE_BITS = 16;
  localparam int DELTA_WORD_BITS = 32;
  localparam int RISING_RATE_LSB = 0;
  localparam int FALLING_RATE_LSB = 8;
  localparam int RATE_BITS = 8;

  // ---------------------------------------------------------------
  // values after master reset
  // ---------------------------------------------------------------
  localparam logic [1:0] RST_CHAN_ENABLE = 2'h3;
  localparam logic RST_CLEAR_PHASE = 1'b1;
  localparam logic [13:0] RST_PHASE_OFFSET = 14'h0000;
  localparam logic [23:0] RST_AMPLITUDE = 24'h000000;
  localparam logic [15:0] RST_RAMP_RATE = 16'h0000;
  localparam logic [31:0] RST_DELTA_WORD = 32'h00000000;

  // ---------------------------------------------------------------
  // counts
  // ---------------------------------------------------------------
  localparam int NUM_CHANNELS = 2;
  localparam int UPDATE_SYNC_STAGES = 2;
endpackage

// ==== verilog/dcrb_chan.sv ====
// one channel's staged and active register set
// assumes write strobe is already gated by this channel's enable bit
`timescale 1ns/1ns
`default_nettype none
module dcrb_chan (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wr_en_i,
  input wire logic [4:0] wr_addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic update_i,
  output logic clear_phase_o,
  output logic [13:0] phase_offset_word_o,
  output logic [23:0] amplitude_control_o,
  output logic [15:0] sweep_ramp_rate_o,
  output logic [7:0] rising_ramp_rate_o,
  output logic [7:0] falling_ramp_rate_o,
  output logic [31:0] rising_delta_word_o,
  output logic [31:0] falling_delta_word_o
);
  logic clr_stage_reg;
  logic [13:0] pow_stage_reg;
  logic [23:0] acr_stage_reg;
  logic [15:0] ramp_stage_reg;
  logic [31:0] rdw_stage_reg;
  logic [31:0] fdw_stage_reg;

  function automatic logic hit(input logic [4:0] a);
    hit = wr_en_i && (wr_addr_i == a);
  endfunction

  // ---------------------------------------------------------------
  // staging buffer
  // ---------------------------------------------------------------
  // writes land here only; nothing reaches the synthesis path yet
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clr_stage_reg <= 1'b0;
      pow_stage_reg <= dcrb_pkg::RST_PHASE_OFFSET;
      acr_stage_reg <= dcrb_pkg::RST_AMPLITUDE;
      ramp_stage_reg <= dcrb_pkg::RST_RAMP_RATE;
      rdw_stage_reg <= dcrb_pkg::RST_DELTA_WORD;
      fdw_stage_reg <= dcrb_pkg::RST_DELTA_WORD;
    end else begin
      // a write in the update cycle wins over the self clear
      if (hit(dcrb_pkg::ADDR_CHANNEL_FUNCTION)) begin
        clr_stage_reg <= wr_data_i[dcrb_pkg::CLEAR_PHASE_BIT];
      end else if (update_i) begin
        clr_stage_reg <= 1'b0; // RULE4
      end
      if (hit(dcrb_pkg::ADDR_PHASE_OFFSET_WORD)) begin
        pow_stage_reg <= wr_data_i[13:0]; // RULE8
      end
      if (hit(dcrb_pkg::ADDR_AMPLITUDE_CONTROL)) begin
        acr_stage_reg <= wr_data_i[23:0]; // RULE8
      end
      if (hit(dcrb_pkg::ADDR_SWEEP_RAMP_RATE)) begin
        ramp_stage_reg <= wr_data_i[15:0]; // RULE8
      end
      if (hit(dcrb_pkg::ADDR_RISING_DELTA_WORD)) begin
        rdw_stage_reg <= wr_data_i; // RULE8
      end
      if (hit(dcrb_pkg::ADDR_FALLING_DELTA_WORD)) begin
        fdw_stage_reg <= wr_data_i; // RULE8
      end
    end
  end

  // ---------------------------------------------------------------
  // active registers
  // ---------------------------------------------------------------
  // copied only on the update strobe so all fields change together
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clear_phase_o <= dcrb_pkg::RST_CLEAR_PHASE; // RULE3
      phase_offset_word_o <= dcrb_pkg::RST_PHASE_OFFSET;
      amplitude_control_o <= dcrb_pkg::RST_AMPLITUDE;
      sweep_ramp_rate_o <= dcrb_pkg::RST_RAMP_RATE;
      rising_delta_word_o <= dcrb_pkg::RST_DELTA_WORD;
      falling_delta_word_o <= dcrb_pkg::RST_DELTA_WORD;
    end else if (update_i) begin
      clear_phase_o <= clr_stage_reg; // RULE4
      phase_offset_word_o <= pow_stage_reg; // RULE7
      amplitude_control_o <= acr_stage_reg;
      sweep_ramp_rate_o <= ramp_stage_reg;
      rising_delta_word_o <= rdw_stage_reg;
      falling_delta_word_o <= fdw_stage_reg;
    end
  end

  // rate halves of the sweep ramp word
  assign rising_ramp_rate_o = sweep_ramp_rate_o[dcrb_pkg::RISING_RATE_LSB +: 8]; // RULE5
  assign falling_ramp_rate_o = sweep_ramp_rate_o[dcrb_pkg::FALLING_RATE_LSB +: 8]; // RULE5

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // written out rather than through hit(): a function body would read the
  // post-edge port values, not the sampled ones
  sequence s_ramp_write;
    wr_en_i && wr_addr_i == dcrb_pkg::ADDR_SWEEP_RAMP_RATE && !update_i;
  endsequence
  sequence s_next_update;
    update_i && !(wr_en_i && wr_addr_i == dcrb_pkg::ADDR_SWEEP_RAMP_RATE);
  endsequence

  a_clear_at_reset: assert property (@(posedge clk_i) // RULE3
    sys_rst_i |=> clear_phase_o && !clr_stage_reg)
    else $error("clear phase bit not set after reset");
  a_clear_self: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE4
    update_i && !(wr_en_i && wr_addr_i == dcrb_pkg::ADDR_CHANNEL_FUNCTION) |=> !clr_stage_reg)
    else $error("clear phase bit did not self clear");
  a_hold_active: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE7
    !update_i |=> $stable(phase_offset_word_o) && $stable(rising_delta_word_o))
    else $error("active value changed without update");
  a_ramp_path: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE8
    s_ramp_write ##1 s_next_update |=>
      rising_ramp_rate_o == $past(wr_data_i[7:0], 2) &&
      falling_ramp_rate_o == $past(wr_data_i[15:8], 2))
    else $error("ramp rate not copied from staging on update");
endmodule // dcrb_chan
`default_nettype wire

// ==== verilog/dcrb_top.sv ====
// channel register bank for a two-channel synthesizer
// assumes serial port logic on clk_i delivers decoded writes; update is a raw pin
`timescale 1ns/1ns
`default_nettype none
// What this block does
// (RULE1) keep two independent copies of each channel register at the same addresses
// (RULE2) a channel register write updates only channels whose enable bits 7:6 are set
// (RULE3) master reset sets the clear phase accumulator bit to one
// (RULE4) the clear phase accumulator bit returns to zero on an update strobe
// (RULE5) ramp rate register: rising rate in bits 7:0, falling rate in 15:8
// (RULE6) enable field 10 picks channel 1, 01 channel 0, 11 both
// (RULE7) enable bits act at once; every other bit waits for an update
// (RULE8) writes go to staging and are copied to active registers on update
module dcrb_top #(
  parameter int CHANNELS = dcrb_pkg::NUM_CHANNELS
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wr_en_i,
  input wire logic [4:0] wr_addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [4:0] rd_addr_i,
  output logic [31:0] rd_data_o,
  input wire logic io_update_i,
  output logic [1:0] chan_enable_o,
  output logic [CHANNELS-1:0] clear_phase_o,
  output logic [CHANNELS*14-1:0] phase_offset_word_o,
  output logic [CHANNELS*24-1:0] amplitude_control_o,
  output logic [CHANNELS*8-1:0] rising_ramp_rate_o,
  output logic [CHANNELS*8-1:0] falling_ramp_rate_o,
  output logic [CHANNELS*32-1:0] rising_delta_word_o,
  output logic [CHANNELS*32-1:0] falling_delta_word_o
);
  // ---------------------------------------------------------------
  // update pin synchroniser and edge detect
  // ---------------------------------------------------------------
  logic upd_meta_reg;
  logic upd_sync_reg;
  logic upd_last_reg;
  logic update_pulse;
  logic [1:0] csr_enable_reg;
  logic [CHANNELS-1:0] chan_wr;
  logic [15:0] ramp_word [CHANNELS];

  // the first stage is read by the second stage only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      upd_meta_reg <= 1'b0;
      upd_sync_reg <= 1'b0;
      upd_last_reg <= 1'b0;
    end else begin
      upd_meta_reg <= io_update_i;
      upd_sync_reg <= upd_meta_reg;
      upd_last_reg <= upd_sync_reg;
    end
  end
  // one pulse per rising edge, so a long strobe copies once
  assign update_pulse = upd_sync_reg && !upd_last_reg;

  // ---------------------------------------------------------------
  // channel selection register
  // ---------------------------------------------------------------
  // not staged: steering must change before the next register byte arrives
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      csr_enable_reg <= dcrb_pkg::RST_CHAN_ENABLE;
    end else if (wr_en_i && wr_addr_i == dcrb_pkg::ADDR_CHANNEL_SELECTION) begin
      csr_enable_reg <= wr_data_i[dcrb_pkg::CHAN_ENABLE_MSB:dcrb_pkg::CHAN_ENABLE_LSB]; // RULE7
    end
  end
  assign chan_enable_o = csr_enable_reg;

  // ---------------------------------------------------------------
  // per-channel register copies
  // ---------------------------------------------------------------
  // bit i of the enable field steers channel i, which gives 10/01/11 decode
  genvar g;
  for (g = 0; g < CHANNELS; g++) begin : g_chan
    assign chan_wr[g] = wr_en_i && csr_enable_reg[g]; // RULE2 RULE6
    dcrb_chan u_chan ( // RULE1
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .wr_en_i(chan_wr[g]),
      .wr_addr_i(wr_addr_i),
      .wr_data_i(wr_data_i),
      .update_i(update_pulse),
      .clear_phase_o(clear_phase_o[g]),
      .phase_offset_word_o(phase_offset_word_o[g*14 +: 14]),
      .amplitude_control_o(amplitude_control_o[g*24 +: 24]),
      .sweep_ramp_rate_o(ramp_word[g]),
      .rising_ramp_rate_o(rising_ramp_rate_o[g*8 +: 8]),
      .falling_ramp_rate_o(falling_ramp_rate_o[g*8 +: 8]),
      .rising_delta_word_o(rising_delta_word_o[g*32 +: 32]),
      .falling_delta_word_o(falling_delta_word_o[g*32 +: 32])
    );
  end

  // ---------------------------------------------------------------
  // readback of active values
  // ---------------------------------------------------------------
  // with both channels enabled channel 0 is shown; enable one at a time
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 32'h00000000;
    end else begin
      automatic int c = (csr_enable_reg == 2'h2) ? 1 : 0;
      case (rd_addr_i)
        dcrb_pkg::ADDR_CHANNEL_SELECTION: rd_data_o <= {24'h000000, csr_enable_reg, 6'h00};
        dcrb_pkg::ADDR_CHANNEL_FUNCTION: rd_data_o <= {30'h00000000, clear_phase_o[c], 1'b0};
        dcrb_pkg::ADDR_PHASE_OFFSET_WORD: rd_data_o <= {18'h00000, phase_offset_word_o[c*14 +: 14]};
        dcrb_pkg::ADDR_AMPLITUDE_CONTROL: rd_data_o <= {8'h00, amplitude_control_o[c*24 +: 24]};
        dcrb_pkg::ADDR_SWEEP_RAMP_RATE: rd_data_o <= {16'h0000, ramp_word[c]};
        dcrb_pkg::ADDR_RISING_DELTA_WORD: rd_data_o <= rising_delta_word_o[c*32 +: 32];
        dcrb_pkg::ADDR_FALLING_DELTA_WORD: rd_data_o <= falling_delta_word_o[c*32 +: 32];
        default: rd_data_o <= 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_pow_write_ch0_only;
    wr_en_i && wr_addr_i == dcrb_pkg::ADDR_PHASE_OFFSET_WORD && csr_enable_reg == 2'h1
      && !update_pulse;
  endsequence

  a_csr_immediate: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE7
    wr_en_i && wr_addr_i == dcrb_pkg::ADDR_CHANNEL_SELECTION |=>
      chan_enable_o == $past(wr_data_i[7:6]))
    else $error("channel enable not applied at once");
  a_steer_ch0: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE6
    s_pow_write_ch0_only ##1 (update_pulse && !wr_en_i) |=>
      phase_offset_word_o[13:0] == $past(wr_data_i[13:0], 2) &&
      phase_offset_word_o[27:14] == $past(g_chan[1].u_chan.pow_stage_reg, 2))
    else $error("write with enable 01 did not reach channel 0 only");
  a_no_enable: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE2
    csr_enable_reg == 2'h0 |-> chan_wr == '0)
    else $error("write reached a disabled channel");
  a_update_edge: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE8
    $rose(upd_sync_reg) |-> update_pulse ##1 !update_pulse)
    else $error("update strobe not a single pulse");
endmodule // dcrb_top
`default_nettype wire

// ==== bench/dcrb_host.sv ====
// host controller model: drives the register write port and the update pin
// assumes one caller at a time, stepping on the rising edge of clk_i
`timescale 1ns/1ns
`default_nettype none
module dcrb_host (
  input wire logic clk_i,
  output logic wr_en_o,
  output logic [4:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic io_update_o
);
  // ---------------------------------------------------------------
  // idle levels
  // ---------------------------------------------------------------
  // port idles with the strobe low and the pin low
  initial begin
    wr_en_o = 1'b0;
    wr_addr_o = 5'h1f;
    wr_data_o = 32'h0;
    io_update_o = 1'b0;
  end

  // ---------------------------------------------------------------
  // transfers
  // ---------------------------------------------------------------
  // one whole word per strobe; lines are inverted after, so stale data never matches
  task automatic write(input logic [4:0] addr, input logic [31:0] data);
    @(posedge clk_i);
    wr_en_o <= 1'b1;
    wr_addr_o <= addr;
    wr_data_o <= data;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    wr_addr_o <= ~addr;
    wr_data_o <= ~data;
  endtask

  // pin high 3 cycles then low 3: covers the 2 sync flops and the copy edge
  task automatic update();
    @(posedge clk_i);
    io_update_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    io_update_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
endmodule // dcrb_host
`default_nettype wire

// ==== bench/dds_channel_register_bank_tb.sv ====
// self-checking bench for the channel register bank
// assumes the host model owns the write port and the update pin
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("BAD t=%0t value mismatch", $time); end end
module dds_channel_register_bank_tb;
  logic clk_i;
  logic sys_rst_i;
  logic wr_en;
  logic [4:0] wr_addr;
  logic [31:0] wr_data;
  logic io_update;
  logic [4:0] rd_addr_i;
  logic [31:0] rd_data;
  logic [1:0] chan_en;
  logic [1:0] clr;
  logic [27:0] pow;
  logic [47:0] amplitude_control;
  logic [15:0] rr;
  logic [15:0] fr;
  logic [63:0] rising_delta_word;
  logic [63:0] falling_delta_word;
  int error_cnt = 0;
  int check_count = 0;

  dcrb_top #(.CHANNELS(2)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wr_en_i(wr_en),
    .wr_addr_i(wr_addr), .wr_data_i(wr_data), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data),
    .io_update_i(io_update), .chan_enable_o(chan_en), .clear_phase_o(clr),
    .phase_offset_word_o(pow), .amplitude_control_o(amplitude_control), .rising_ramp_rate_o(rr),
    .falling_ramp_rate_o(fr), .rising_delta_word_o(rising_delta_word), .falling_delta_word_o(falling_delta_word));
  dcrb_host u_host (.clk_i(clk_i), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .io_update_o(io_update));

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // defaults after master reset, csr read back in bits 7:6
  task automatic t_reset();
    repeat (2) @(negedge clk_i);
    `CHK(clr, 2'h3)
    `CHK(chan_en, 2'h3)
    `CHK(pow, 28'h0)
    `CHK(rd_data, 32'h000000c0)
  endtask

  // staged word stays hidden until the update; extra upper bits are dropped
  task automatic t_staging();
    u_host.write(dcrb_pkg::ADDR_PHASE_OFFSET_WORD, 32'hffffd234);
    repeat (4) @(negedge clk_i);
    `CHK(pow, 28'h0)
    u_host.update();
    `CHK(pow, {14'h1234, 14'h1234})
    `CHK(clr, 2'h0)
  endtask

  // per-channel steering by the enable field, codes 01, 10 and 11 all used
  task automatic t_steer();
    u_host.write(dcrb_pkg::ADDR_CHANNEL_SELECTION, 32'h00000040);
    @(negedge clk_i);
    `CHK(chan_en, 2'h1)
    u_host.write(dcrb_pkg::ADDR_SWEEP_RAMP_RATE, 32'h0000a55a);
    u_host.write(dcrb_pkg::ADDR_FALLING_DELTA_WORD, 32'h33334444);
    u_host.write(dcrb_pkg::ADDR_CHANNEL_SELECTION, 32'h00000080);
    u_host.write(dcrb_pkg::ADDR_SWEEP_RAMP_RATE, 32'h00003cc3);
    u_host.write(dcrb_pkg::ADDR_AMPLITUDE_CONTROL, 32'h00abcdef);
    u_host.write(dcrb_pkg::ADDR_CHANNEL_FUNCTION, 32'h00000002);
    u_host.write(5'h0a, 32'hffffffff);
    u_host.write(dcrb_pkg::ADDR_CHANNEL_SELECTION, 32'h000000c0);
    u_host.write(dcrb_pkg::ADDR_RISING_DELTA_WORD, 32'h11112222);
    @(negedge clk_i);
    `CHK(rr, 16'h0000)
    u_host.update();
    `CHK(rr, {8'hc3, 8'h5a})
    `CHK(fr, {8'h3c, 8'ha5})
    `CHK(amplitude_control, {24'habcdef, 24'h000000})
    `CHK(falling_delta_word, {32'h00000000, 32'h33334444})
    `CHK(rising_delta_word, {32'h11112222, 32'h11112222})
    `CHK(clr, 2'h2)
    `CHK(pow, {14'h1234, 14'h1234})
    u_host.write(dcrb_pkg::ADDR_CHANNEL_SELECTION, 32'h00000080);
    rd_addr_i <= dcrb_pkg::ADDR_SWEEP_RAMP_RATE;
    repeat (2) @(negedge clk_i);
    `CHK(rd_data, 32'h00003cc3)
  endtask

  // writes land one cycle before the copy pulse; then a write with no channel enabled
  task automatic t_late_write();
    u_host.write(dcrb_pkg::ADDR_CHANNEL_SELECTION, 32'h00000040);
    fork
      u_host.update();
      begin
        @(posedge clk_i);
        u_host.write(dcrb_pkg::ADDR_PHASE_OFFSET_WORD, 32'h00002bcd);
      end
    join
    `CHK(pow, {14'h1234, 14'h2bcd})
    `CHK(clr, 2'h0)
    fork
      u_host.update();
      begin
        @(posedge clk_i);
        u_host.write(dcrb_pkg::ADDR_SWEEP_RAMP_RATE, 32'h0000f00f);
      end
    join
    `CHK(rr, {8'hc3, 8'h0f})
    `CHK(fr, {8'h3c, 8'hf0})
    u_host.write(dcrb_pkg::ADDR_CHANNEL_SELECTION, 32'h00000000);
    @(negedge clk_i);
    `CHK(chan_en, 2'h0)
    u_host.write(dcrb_pkg::ADDR_FALLING_DELTA_WORD, 32'h55556666);
    u_host.update();
    `CHK(falling_delta_word, {32'h00000000, 32'h33334444})
    `CHK(rd_data, 32'h0000f00f)
  endtask

  // ---------------------------------------------------------------
  // verdict
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // watchdog: a hung run counts as a mismatch
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end

  // main sequence: reset held 6 cycles, then the scenarios in order
  initial begin
    sys_rst_i = 1'b1;
    rd_addr_i = dcrb_pkg::ADDR_CHANNEL_SELECTION;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_staging();
    t_steer();
    t_late_write();
    end_of_test();
  end
endmodule // dds_channel_register_bank_tb
`default_nettype wire
